// >>> bench/arc_ctrl_asserts.sv
// assertion checker for the auxiliary regulator configuration control
`include "arc_defs.vh"
module arc_ctrl_asserts (
   // clock and reset
   input wire logic       clk, reset_n,
   // writes, mode and monitors
   input wire logic       cfg_write, wr_aux_reg_on, wr_aux_share_select, batt_below_uv,
   input wire logic [2:0] sys_mode,
   // state and outputs
   input wire logic [1:0] config_state,
   input wire logic       config_locked, spi_fail_set, aux_overcurrent_flag,
   input wire logic       aux_undervoltage_flag, aux_enable, lp_stage_on
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   wire none_st  = config_state == `ARC_CFG_NONE;
   wire share_st = config_state == `ARC_CFG_SHARE;
   property p_lock_hold; config_locked |=> config_locked; endproperty
   a_lock_hold: assert property (p_lock_hold) else $error("lock dropped");
   property p_cfg_stable; config_locked |=> $stable(config_state); endproperty
   a_cfg_stable: assert property (p_cfg_stable) else $error("locked config changed");
   property p_alone_cfg;
      cfg_write && wr_aux_reg_on && !wr_aux_share_select && sys_mode == `ARC_MODE_NORMAL && none_st
      |=> config_state == `ARC_CFG_ALONE;
   endproperty
   a_alone_cfg: assert property (p_alone_cfg) else $error("stand-alone not taken");
   property p_share_cfg; cfg_write && wr_aux_share_select && none_st |=> share_st; endproperty
   a_share_cfg: assert property (p_share_cfg) else $error("sharing not taken");
   property p_fail; cfg_write && share_st && (wr_aux_reg_on || !wr_aux_share_select) |=> ##[0:1] spi_fail_set; endproperty
   a_fail: assert property (p_fail) else $error("no failure pulse");
   property p_share_noflag; share_st |-> !aux_overcurrent_flag && !aux_undervoltage_flag; endproperty
   a_share_noflag: assert property (p_share_noflag) else $error("flag under sharing");
   property p_off_mode; sys_mode == `ARC_MODE_INIT || sys_mode == `ARC_MODE_FAILSAFE |=> !aux_enable; endproperty
   a_off_mode: assert property (p_off_mode) else $error("enabled in init or fail-safe");
   property p_batt_off; batt_below_uv |=> !aux_enable; endproperty
   a_batt_off: assert property (p_batt_off) else $error("enabled under battery undervoltage");
   property p_normal_hp; sys_mode == `ARC_MODE_NORMAL |=> !lp_stage_on; endproperty
   a_normal_hp: assert property (p_normal_hp) else $error("low-power stage in normal");
   c_reject: cover property (share_st && spi_fail_set);
   c_oc: cover property (config_state == `ARC_CFG_ALONE && aux_overcurrent_flag);
   c_stop_on: cover property (aux_enable && sys_mode == `ARC_MODE_STOP);
endmodule // arc_ctrl_asserts
bind arc_ctrl arc_ctrl_asserts chk_u (.*);

// >>> bench/arc_pass_model.sv
// far-side model: external pass transistor with current shunt
module arc_pass_model #(
   parameter logic [7:0] RISE = 8'h40,
   parameter logic [7:0] FALL = 8'h20,
   parameter logic [7:0] LIM  = 8'hC0
) (
   // drive from the block and load on the output
   input  wire logic       aux_enable,
   input  wire logic [7:0] load,
   // monitor levels back to the block
   output wire logic       shunt_limit_reached,
   output wire logic       aux_output_uv,
   output wire logic       drive_above_rise,
   output wire logic       drive_below_fall
);
   timeunit 1ns;
   timeprecision 1ns;
   wire [7:0] drive = aux_enable ? load : 8'h00;
   assign drive_above_rise    = drive > RISE;
   assign drive_below_fall    = drive < FALL;
   assign shunt_limit_reached = drive >= LIM;
   // a limited output sags below its level
   assign aux_output_uv       = drive >= LIM;
endmodule // arc_pass_model

// >>> bench/tb_arc_ctrl.sv
// self-checking bench for the auxiliary regulator configuration control
`include "arc_defs.vh"
module tb_arc_ctrl;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 0, reset_n = 0, soft_reset = 0, cfg_write = 0, batt_below_uv = 0, clear_overcurrent = 0;
   logic wr_aux_reg_on = 0, wr_aux_share_select = 0, wr_aux_share_keep_in_stop = 0, clear_undervoltage = 0;
   logic wr_aux_stay_off_after_batt_uv = 0, wr_aux_voltage_select = 0;
   logic [2:0] sys_mode = 3'h0;
   logic [7:0] load = 8'h00;
   logic [7:0] ld[4];
   logic [1:0] hx[4] = '{2'h1, 2'h3, 2'h3, 2'h1};
   logic [1:0] q[$];
   wire [1:0] config_state;
   wire aux_reg_on, aux_share_select, aux_share_keep_in_stop, aux_stay_off_after_batt_uv, aux_voltage_select;
   wire config_locked, spi_fail_set, aux_overcurrent_flag, aux_undervoltage_flag, aux_enable, hp_stage_on;
   wire lp_stage_on, volt_1v8, current_limit_on, shunt_limit_reached, aux_output_uv;
   wire drive_above_rise, drive_below_fall;
   int fail_count = 0, checks = 0;
   arc_ctrl dut_u (.*);
   arc_pass_model pm_u (.*);
   always #50 clk = ~clk;
   ////////////////////////////////////////////////////////////////
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task end_sim;
      if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task c(input int n);
      repeat (n) @(negedge clk);
   endtask
   task md(input logic [2:0] v);
      sys_mode = v;
      c(3);
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      c(1);
      s = 1'b0;
      c(2);
   endtask
   // v = {on, share, keep in stop, stay off}; rej notes an expected failure pulse
   task w(input logic [3:0] v, input logic rej);
      {wr_aux_reg_on, wr_aux_share_select, wr_aux_share_keep_in_stop, wr_aux_stay_off_after_batt_uv} = v;
      wr_aux_voltage_select = 1'($urandom);
      cfg_write = 1'b1;
      if (rej) q.push_back(`ARC_CFG_SHARE);
      c(1);
      cfg_write = 1'b0;
      c(2);
   endtask
   task rst;
      reset_n = 1'b0;
      c(4);
      reset_n = 1'b1;
      c(1);
   endtask
   // failure pulses are matched against the oldest note
   always @(negedge clk) if (spi_fail_set === 1'b1) begin
      if (q.size() == 0) chk(8'(spi_fail_set), 8'h00);
      else chk(8'(config_state), 8'(q.pop_front()));
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h96ba6b74));
      rst();
      sys_mode = `ARC_MODE_NORMAL;
      w(4'h8, 0);
      chk({config_state, config_locked, aux_reg_on}, {`ARC_CFG_ALONE, 2'h3});
      chk({aux_enable, hp_stage_on, lp_stage_on, volt_1v8}, {3'h6, wr_aux_voltage_select});
      w(4'hC, 0);
      chk(config_state, `ARC_CFG_ALONE);
      w(4'h0, 0);
      chk({aux_reg_on, aux_enable}, 2'h0);
      w(4'h8, 0);
      pulse(soft_reset);
      chk({config_state, config_locked}, {`ARC_CFG_ALONE, 1'h1});
      w(4'h8, 0);
      md(`ARC_MODE_SLEEP);
      chk(aux_enable, 1);
      md(`ARC_MODE_RESTART);
      chk(aux_enable, 1);
      load = 8'h10;
      md(`ARC_MODE_STOP);
      ld = '{8'h10, 8'h41 + 8'($urandom % 64), 8'h30, 8'h10};
      foreach (ld[i]) begin
         load = ld[i];
         c(3);
         chk({aux_enable, hp_stage_on, lp_stage_on}, {1'h1, hx[i]});
      end
      md(`ARC_MODE_FAILSAFE);
      chk(aux_enable, 0);
      md(`ARC_MODE_INIT);
      chk(aux_enable, 0);
      md(`ARC_MODE_NORMAL);
      w(4'h8, 0);
      load = 8'hC0 + 8'($urandom % 64);
      c(3);
      chk({current_limit_on, aux_overcurrent_flag, aux_undervoltage_flag}, 3'h7);
      pulse(clear_overcurrent);
      chk(aux_overcurrent_flag, 1);
      load = 8'h10;
      c(2);
      pulse(clear_overcurrent);
      pulse(clear_undervoltage);
      chk({current_limit_on, aux_overcurrent_flag, aux_undervoltage_flag}, 3'h0);
      batt_below_uv = 1'b1;
      c(3);
      chk(aux_enable, 0);
      batt_below_uv = 1'b0;
      c(3);
      chk(aux_enable, 1);
      w(4'h9, 0);
      pulse(batt_below_uv);
      c(2);
      chk(aux_enable, 0);
      rst();
      sys_mode = `ARC_MODE_INIT;
      w(4'h4, 0);
      chk({config_state, config_locked, aux_share_select, aux_enable}, {`ARC_CFG_SHARE, 3'h6});
      w(4'hC, 1);
      w(4'h0, 1);
      chk(config_state, `ARC_CFG_SHARE);
      load = 8'hF0;
      md(`ARC_MODE_NORMAL);
      chk({aux_enable, aux_overcurrent_flag, aux_undervoltage_flag, volt_1v8}, 4'h8);
      md(`ARC_MODE_STOP);
      chk({aux_enable, aux_share_select}, 2'h1);
      md(`ARC_MODE_NORMAL);
      chk(aux_enable, 1);
      w(4'h6, 0);
      md(`ARC_MODE_STOP);
      chk(aux_enable, 1);
      md(`ARC_MODE_FAILSAFE);
      chk(aux_enable, 0);
      for (int i = 0; i < 10 && q.size() > 0; i++) c(1);
      chk(8'(q.size()), 8'h00);
      end_sim();
   end
endmodule // tb_arc_ctrl

// >>> rtl/arc_ctrl.v
// auxiliary regulator configuration and mode control
//
// Behaviour
// - setting on bit in normal mode selects stand-alone configuration
// - setting share-select bit selects load-sharing configuration
// - first setting write locks configuration until power loss, survives soft reset
// - change attempts on locked stand-alone config ignored, no failure flag
// - change attempts after load-sharing selected raise failure flag, config kept
// - stand-alone: on bit still switches regulator after lock
// - stand-alone off in init/fail-safe, set in normal, held in stop/sleep/restart
// - load sharing follows main supply, active in normal, configurable in any mode
// - keep-in-stop clear: sharing off in stop, select stays, resumes in normal
// - keep-in-stop set: sharing stays active in stop mode
// - stop mode: low-power stage, high-power added by drive current hysteresis
// - normal mode: only high-power stage runs
// - battery undervoltage turns off; auto restart unless stay-off bit set
// - stand-alone overcurrent sets sticky flag, clearable only after condition ends
// - stand-alone output undervoltage reported by undervoltage flag
// - load sharing: no flags, regulator shut down in fail-safe
// - load sharing never signals overcurrent
// - stand-alone voltage select: clear 3.3V, set 1.8V; ignored when sharing
`include "arc_defs.vh"

module arc_ctrl (
   // clock and power-on reset
   input  wire       clk,
   input  wire       reset_n,
   // soft reset (does not touch the configuration lock)
   input  wire       soft_reset,
   // system mode
   input  wire [2:0] sys_mode,
   // software write port
   input  wire       cfg_write,
   input  wire       wr_aux_reg_on,
   input  wire       wr_aux_share_select,
   input  wire       wr_aux_share_keep_in_stop,
   input  wire       wr_aux_stay_off_after_batt_uv,
   input  wire       wr_aux_voltage_select,
   input  wire       clear_overcurrent,
   input  wire       clear_undervoltage,
   // analog monitors
   input  wire       batt_below_uv,
   input  wire       shunt_limit_reached,
   input  wire       aux_output_uv,
   input  wire       drive_above_rise,
   input  wire       drive_below_fall,
   // control bits as read back
   output reg        aux_reg_on,
   output reg        aux_share_select,
   output reg        aux_share_keep_in_stop,
   output reg        aux_stay_off_after_batt_uv,
   output reg        aux_voltage_select,
   output reg  [1:0] config_state,
   output reg        config_locked,
   // status
   output reg        spi_fail_set,
   output wire       aux_overcurrent_flag,
   output wire       aux_undervoltage_flag,
   // regulator drive
   output reg        aux_enable,
   output reg        hp_stage_on,
   output reg        lp_stage_on,
   output reg        volt_1v8,
   output reg        current_limit_on
);

   ////////////////////////////////////////////////////////////////////////
   // configuration select and lock

   wire normal = (sys_mode == `ARC_MODE_NORMAL);
   wire stop   = (sys_mode == `ARC_MODE_STOP);
   wire fsafe  = (sys_mode == `ARC_MODE_FAILSAFE);
   wire init   = (sys_mode == `ARC_MODE_INIT);
   wire alone  = (config_state == `ARC_CFG_ALONE);
   wire share  = (config_state == `ARC_CFG_SHARE);

   // a write that would pick the other configuration
   wire try_alone = cfg_write && wr_aux_reg_on && !wr_aux_share_select && normal;
   wire try_share = cfg_write && wr_aux_share_select;
   wire change_on_share = cfg_write && share && (wr_aux_reg_on || !wr_aux_share_select);

   reg [1:0] next_config_state;
   reg       next_config_locked;

   // only an unlocked block takes a new choice; sharing wins a tie
   always @* begin
      next_config_state  = config_state;
      next_config_locked = config_locked;
      if (!config_locked) begin
         if (try_share) begin
            next_config_state  = `ARC_CFG_SHARE;
            next_config_locked = 1'h1;
         end else if (try_alone) begin
            next_config_state  = `ARC_CFG_ALONE;
            next_config_locked = 1'h1;
         end
      end
   end

   // lock and configuration: cleared only by power-on reset
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         config_state  <= `ARC_RST_CFG;
         config_locked <= `ARC_RST_BIT;
      end else begin
         config_state  <= next_config_state;
         config_locked <= next_config_locked;
      end
   end

   // failure pulse for change attempts after sharing was locked
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         spi_fail_set <= 1'h0;
      end else begin
         spi_fail_set <= config_locked && change_on_share;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // control bits (soft reset clears these, share select reloaded from the sharing configuration, not the lock)

   reg next_aux_reg_on;
   reg next_aux_share_select;
   reg next_aux_share_keep_in_stop;
   reg next_aux_stay_off_after_batt_uv;
   reg next_aux_voltage_select;

   always @* begin
      next_aux_reg_on                 = aux_reg_on;
      next_aux_share_select           = aux_share_select;
      next_aux_share_keep_in_stop     = aux_share_keep_in_stop;
      next_aux_stay_off_after_batt_uv = aux_stay_off_after_batt_uv;
      next_aux_voltage_select         = aux_voltage_select;
      if (soft_reset) begin
         next_aux_reg_on                 = `ARC_RST_BIT;
         next_aux_share_keep_in_stop     = `ARC_RST_BIT;
         next_aux_stay_off_after_batt_uv = `ARC_RST_BIT;
         next_aux_voltage_select         = `ARC_RST_BIT;
         next_aux_share_select           = share;
      end else if (cfg_write) begin
         next_aux_share_keep_in_stop     = wr_aux_share_keep_in_stop;
         next_aux_stay_off_after_batt_uv = wr_aux_stay_off_after_batt_uv;
         if (normal) begin
            next_aux_voltage_select = wr_aux_voltage_select;
         end
         // on bit writable only unless sharing owns the regulator
         if (!share && normal && (alone || !wr_aux_share_select)) begin
            next_aux_reg_on = wr_aux_reg_on;
         end
         // select bit: sets once, change on alone ignored silently
         if (!config_locked) begin
            next_aux_share_select = wr_aux_share_select;
         end
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aux_reg_on                 <= `ARC_RST_BIT;
         aux_share_select           <= `ARC_RST_BIT;
         aux_share_keep_in_stop     <= `ARC_RST_BIT;
         aux_stay_off_after_batt_uv <= `ARC_RST_BIT;
         aux_voltage_select         <= `ARC_RST_BIT;
      end else begin
         aux_reg_on                 <= next_aux_reg_on;
         aux_share_select           <= next_aux_share_select;
         aux_share_keep_in_stop     <= next_aux_share_keep_in_stop;
         aux_stay_off_after_batt_uv <= next_aux_stay_off_after_batt_uv;
         aux_voltage_select         <= next_aux_voltage_select;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // battery undervoltage latch

   reg uv_latched_off;
   reg next_uv_latched_off;

   // released only by a fresh on write in normal mode
   always @* begin
      next_uv_latched_off = uv_latched_off;
      if (batt_below_uv && aux_stay_off_after_batt_uv) begin
         next_uv_latched_off = 1'h1;
      end else if (cfg_write && normal && alone && wr_aux_reg_on) begin
         next_uv_latched_off = 1'h0;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         uv_latched_off <= 1'h0;
      end else begin
         uv_latched_off <= next_uv_latched_off;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // enable per mode

   reg alone_hold;
   reg next_enable;

   // stand-alone state held through stop, sleep and restart
   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         alone_hold <= 1'h0;
      end else if (init || fsafe) begin
         alone_hold <= 1'h0;
      end else if (normal) begin
         alone_hold <= aux_reg_on;
      end
   end

   always @* begin
      next_enable = 1'h0;
      if (alone) begin
         case (sys_mode)
            `ARC_MODE_INIT:     next_enable = 1'h0;
            `ARC_MODE_NORMAL:   next_enable = aux_reg_on;
            `ARC_MODE_STOP:     next_enable = alone_hold;
            `ARC_MODE_SLEEP:    next_enable = alone_hold;
            `ARC_MODE_RESTART:  next_enable = alone_hold;
            `ARC_MODE_FAILSAFE: next_enable = 1'h0;
            default:            next_enable = 1'h0;
         endcase
      end else if (share) begin
         case (sys_mode)
            `ARC_MODE_INIT:     next_enable = 1'h0;
            `ARC_MODE_NORMAL:   next_enable = 1'h1;
            `ARC_MODE_RESTART:  next_enable = 1'h1;
            `ARC_MODE_STOP:     next_enable = aux_share_keep_in_stop;
            `ARC_MODE_SLEEP:    next_enable = 1'h0;
            `ARC_MODE_FAILSAFE: next_enable = 1'h0;
            default:            next_enable = 1'h0;
         endcase
      end
      if (batt_below_uv || uv_latched_off) begin
         next_enable = 1'h0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // stage selection with drive-current hysteresis

   reg hp_boost;
   reg next_hp_boost;
   reg next_hp_stage_on;
   reg next_lp_stage_on;
   reg next_volt_1v8;
   reg next_current_limit_on;

   // hysteresis band: between thresholds the stage keeps its state
   always @* begin
      next_hp_boost = hp_boost;
      if (!stop) begin
         next_hp_boost = 1'h0;
      end else if (drive_above_rise) begin
         next_hp_boost = 1'h1;
      end else if (drive_below_fall) begin
         next_hp_boost = 1'h0;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hp_boost <= 1'h0;
      end else begin
         hp_boost <= next_hp_boost;
      end
   end

   // stage, voltage and limit drive
   always @* begin
      next_hp_stage_on      = 1'h0;
      next_lp_stage_on      = 1'h0;
      next_volt_1v8         = 1'h0;
      next_current_limit_on = 1'h0;
      if (next_enable) begin
         if (stop) begin
            next_lp_stage_on = 1'h1;
            next_hp_stage_on = hp_boost;
         end else begin
            next_hp_stage_on = 1'h1;
         end
      end
      // voltage select and limit mean nothing under sharing
      if (alone) begin
         next_volt_1v8         = aux_voltage_select;
         next_current_limit_on = shunt_limit_reached;
      end
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         aux_enable       <= 1'h0;
         hp_stage_on      <= 1'h0;
         lp_stage_on      <= 1'h0;
         volt_1v8         <= 1'h0;
         current_limit_on <= 1'h0;
      end else begin
         aux_enable       <= next_enable;
         hp_stage_on      <= next_hp_stage_on;
         lp_stage_on      <= next_lp_stage_on;
         volt_1v8         <= next_volt_1v8;
         current_limit_on <= next_current_limit_on;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // status flags, only in stand-alone

   arc_flag u_oc_flag (
      .clk         (clk),
      .reset_n     (reset_n),
      .enable      (alone),
      .event_in    (shunt_limit_reached && aux_enable),
      .cond_active (shunt_limit_reached),
      .clear       (clear_overcurrent),
      .flag        (aux_overcurrent_flag)
   );

   arc_flag u_uv_flag (
      .clk         (clk),
      .reset_n     (reset_n),
      .enable      (alone),
      .event_in    (aux_output_uv && aux_enable),
      .cond_active (1'h0),
      .clear       (clear_undervoltage),
      .flag        (aux_undervoltage_flag)
   );

endmodule // arc_ctrl

// >>> rtl/arc_flag.v
// sticky status flag, set wins over clear, clear only when condition gone
module arc_flag (
   // clock and reset
   input  wire clk,
   input  wire reset_n,
   // control
   input  wire enable,
   input  wire event_in,
   input  wire cond_active,
   input  wire clear,
   // status
   output reg  flag
);

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flag <= 1'h0;
      end else if (!enable) begin
         flag <= 1'h0;
      end else if (event_in) begin
         flag <= 1'h1;
      end else if (clear && !cond_active) begin
         flag <= 1'h0;
      end
   end

endmodule // arc_flag

// >>> shared/arc_defs.vh
// constants for the auxiliary regulator configuration control block
`ifndef ARC_DEFS_VH
`define ARC_DEFS_VH

// system operating mode encodings
`define ARC_MODE_INIT      3'h0
`define ARC_MODE_NORMAL    3'h1
`define ARC_MODE_STOP      3'h2
`define ARC_MODE_SLEEP     3'h3
`define ARC_MODE_RESTART   3'h4
`define ARC_MODE_FAILSAFE  3'h5

// configuration encodings
`define ARC_CFG_NONE       2'h0
`define ARC_CFG_ALONE      2'h1
`define ARC_CFG_SHARE      2'h2

// reset values
`define ARC_RST_CFG        2'h0
`define ARC_RST_BIT        1'h0

`endif
